// *** logic/fpc_cmd_decoder.sv ***
// Command interpreter of a parallel flash, reached over Avalon-MM.
// Assumes P/E controller and non-volatile storage on the same clock.
//
// Overview of operation
// - 60h then 03h loads burst config, array read
// - Burst config value taken from A1-A16
// - 60h then 01h protects addressed block
// - During block protect only 70h accepted
// - Protection flags live in non-volatile storage
// - 60h then D0h unprotects every block
// - During unprotect only 70h accepted
// - C0h then address/data programs protection word
// - Protection program start switches reads to status
// - Lock word bit1 user, bit0 factory
// - Programming locked segment flags error, no change
// - Protection register program cannot be suspended
// - Status pin starts in ready/busy mode
// - B8h then code configures status pin
// - Pin config refused while busy or suspended
// - Pulse modes drive pin low 250ns
// - Undefined pin code flags status error
// - FFh returns to array read mode
// - 90h identifier reads, 98h query reads
// - 20h then D0h erases addressed block
// - 40h or 10h then address/data programs word
// - Pin codes 00h..03h select the four modes
// - Error bits 1,4,5 sticky until 50h
// - Status bit 7 shows controller idle
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module fpc_cmd_decoder #(
  // Identity values are arbitrary
  parameter logic [15:0] MFR_CODE = 16'h00A5,
  parameter logic [15:0] DEV_CODE = 16'h5A01
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // Avalon-MM slave
  input  wire logic [fpc_pkg::AVS_AW-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // Storage read side
  output logic      [fpc_pkg::FA_W-1:0]    store_addr,
  input  wire logic [15:0]                 array_word,
  input  wire logic [15:0]                 query_word,
  input  wire logic [15:0]                 otp_word,
  input  wire logic [1:0]                  otp_lock,
  input  wire logic                        block_protected,
  // Program/erase controller
  output logic                             pe_start,
  output logic      [2:0]                  pe_op,
  output logic      [fpc_pkg::FA_W-1:0]    pe_addr,
  output logic      [15:0]                 pe_data,
  output logic                             pe_buf_load,
  output logic                             pe_suspend,
  output logic                             pe_resume,
  input  wire logic                        pe_done,
  input  wire logic                        pe_fail,
  input  wire logic                        pe_paused,
  // Status pin and burst setting
  output logic                             status_indicator_pin_o,
  output logic                             status_indicator_pin_oe_n,
  output logic      [15:0]                 burst_config_value
);
  import fpc_pkg::*;

  function automatic logic [21:0] fpc_be_merge(input logic [21:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
    logic [31:0] r;
    r = {10'h000, old};
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r[21:0];
  endfunction

  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [21:0] faddr_ff;
  fpc_rmode_t  rmode_ff;
  fpc_rmode_t  nxt_rmode;
  fpc_cst_t    cst_ff;
  fpc_cst_t    nxt_cst;
  fpc_op_t     act_op_ff;
  fpc_op_t     nxt_op;
  logic        active_ff;
  logic        susp_req_ff;
  logic        susp_erase_ff;
  logic        susp_prog_ff;
  logic        err_erase_ff;
  logic        err_prog_ff;
  logic        err_bp_ff;
  logic [15:0] bcr_ff;
  logic [1:0]  pin_cfg_ff;
  logic [3:0]  pcnt_ff;
  logic        pin_oe_n_ff;
  logic        pin_o_ff;
  logic [3:0]  bcnt_ff;
  logic [17:0] bbase_ff;
  logic        pe_start_ff;
  fpc_op_t     pe_op_ff;
  logic [21:0] pe_addr_ff;
  logic [15:0] pe_data_ff;
  logic        pe_load_ff;
  logic        pe_susp_ff;
  logic        pe_res_ff;

  logic        req_new;
  logic        wr_cmd;
  logic [7:0]  c;
  logic [15:0] wd16;
  logic [7:0]  status_byte;
  logic [15:0] read_word;
  logic        susp_any;
  logic        otp_bad;
  logic        ev_start;
  logic        ev_suspend;
  logic        ev_resume;
  logic        ev_clear;
  logic        ev_perr;
  logic        ev_eerr;
  logic        ev_bperr;
  logic        ev_bcr;
  logic        ev_pincfg;
  logic        ev_load;

  // A request is taken once; the answer follows one cycle later
  assign req_new  = (avs_read | avs_write) & wait_ff;
  assign wr_cmd   = req_new & avs_write & (avs_address == OFF_CMD) & (&avs_byteenable[1:0]);
  assign c        = avs_writedata[7:0];
  assign wd16     = avs_writedata[15:0];
  assign susp_any = susp_erase_ff | susp_prog_ff;

  assign status_byte = {~active_ff, susp_erase_ff, err_erase_ff, err_prog_ff,
                        1'b0, susp_prog_ff, err_bp_ff, 1'b0};

  // Factory segment is locked from manufacture; lock word shares user lock
  always_comb begin
    if (faddr_ff >= OTP_USER_LO && faddr_ff <= OTP_USER_HI) begin
      otp_bad = ~otp_lock[1];
    end else if (faddr_ff > OTP_LOCK && faddr_ff <= OTP_FACT_HI) begin
      otp_bad = ~otp_lock[0];
    end else if (faddr_ff == OTP_LOCK) begin
      otp_bad = ~otp_lock[1];
    end else begin
      otp_bad = 1'b1;
    end
  end

  always_comb begin
    read_word = 16'h0000;
    if (active_ff || rmode_ff == RM_STATUS) begin
      read_word = {8'h00, status_byte};
    end else begin
      unique case (rmode_ff)
        RM_ARRAY: read_word = array_word;
        RM_QUERY: read_word = query_word;
        RM_IDENT: begin
          if (faddr_ff == ID_MFR_ADDR) begin
            read_word = MFR_CODE;
          end else if (faddr_ff == ID_DEV_ADDR) begin
            read_word = DEV_CODE;
          end else if (faddr_ff[15:0] == ID_PROT_OFS) begin
            read_word = {15'h0000, block_protected};
          end else if (faddr_ff == ID_BCR_ADDR) begin
            read_word = bcr_ff;
          end else if (faddr_ff >= OTP_LOCK && faddr_ff <= OTP_USER_HI) begin
            read_word = otp_word;
          end
        end
        RM_STATUS: read_word = {8'h00, status_byte};
      endcase
    end
  end

  // Command decode
  always_comb begin
    nxt_cst    = cst_ff;
    nxt_rmode  = rmode_ff;
    nxt_op     = act_op_ff;
    ev_start   = 1'b0;
    ev_suspend = 1'b0;
    ev_resume  = 1'b0;
    ev_clear   = 1'b0;
    ev_perr    = 1'b0;
    ev_eerr    = 1'b0;
    ev_bperr   = 1'b0;
    ev_bcr     = 1'b0;
    ev_pincfg  = 1'b0;
    ev_load    = 1'b0;
    if (wr_cmd) begin
      unique case (cst_ff)
        CS_IDLE: begin
          if (active_ff) begin
            // Protect, unprotect and OTP runs take only a status read
            if (c == CMD_READ_STATUS) begin
              nxt_rmode = RM_STATUS;
            end else if (c == CMD_SUSPEND && !susp_req_ff &&
                         (act_op_ff == OP_WORD || act_op_ff == OP_BUF ||
                          act_op_ff == OP_ERASE)) begin
              ev_suspend = 1'b1;
            end
          end else begin
            unique case (c)
              CMD_READ_ARRAY:  nxt_rmode = RM_ARRAY;
              CMD_READ_ID:     nxt_rmode = RM_IDENT;
              CMD_READ_QUERY:  nxt_rmode = RM_QUERY;
              CMD_READ_STATUS: nxt_rmode = RM_STATUS;
              CMD_CLR_STATUS:  ev_clear = !susp_any;
              CMD_CONFIRM: begin
                ev_resume = susp_any;
                nxt_rmode = susp_any ? RM_STATUS : rmode_ff;
              end
              CMD_PROG_A, CMD_PROG_B: begin
                if (!susp_prog_ff) begin
                  nxt_cst   = CS_WORD;
                  nxt_rmode = RM_STATUS;
                end
              end
              CMD_BUF_PROG: begin
                if (!susp_prog_ff) begin
                  nxt_cst   = CS_BUF_CNT;
                  nxt_rmode = RM_STATUS;
                end
              end
              CMD_ERASE:     nxt_cst = susp_any ? CS_IDLE : CS_ERASE;
              CMD_CFG_SETUP: nxt_cst = susp_any ? CS_IDLE : CS_CFG60;
              CMD_OTP_PROG:  nxt_cst = susp_any ? CS_IDLE : CS_OTP;
              CMD_PIN_CFG:   nxt_cst = susp_any ? CS_IDLE : CS_PINCFG;
              default:       nxt_cst = CS_IDLE;
            endcase
          end
        end
        CS_CFG60: begin
          nxt_cst   = CS_IDLE;
          nxt_rmode = RM_STATUS;
          if (c == CMD_CFG_BURST) begin
            ev_bcr    = 1'b1;
            nxt_rmode = RM_ARRAY;
          end else if (c == CMD_CFG_PROTECT) begin
            ev_start = 1'b1;
            nxt_op   = OP_PROT;
          end else if (c == CMD_CONFIRM) begin
            ev_start = 1'b1;
            nxt_op   = OP_UNPROT;
          end else begin
            ev_perr = 1'b1;
            ev_eerr = 1'b1;
          end
        end
        CS_ERASE: begin
          nxt_cst   = CS_IDLE;
          nxt_rmode = RM_STATUS;
          if (c != CMD_CONFIRM) begin
            ev_perr = 1'b1;
            ev_eerr = 1'b1;
          end else if (block_protected) begin
            ev_bperr = 1'b1;
            ev_eerr  = 1'b1;
          end else begin
            ev_start = 1'b1;
            nxt_op   = OP_ERASE;
          end
        end
        CS_WORD: begin
          nxt_cst = CS_IDLE;
          if (block_protected) begin
            ev_bperr = 1'b1;
            ev_perr  = 1'b1;
          end else begin
            ev_start = 1'b1;
            nxt_op   = OP_WORD;
          end
        end
        CS_OTP: begin
          nxt_cst   = CS_IDLE;
          nxt_rmode = RM_STATUS;
          ev_perr   = otp_bad;
          ev_start  = !otp_bad;
          nxt_op    = otp_bad ? act_op_ff : OP_OTP;
        end
        CS_PINCFG: begin
          nxt_cst   = CS_IDLE;
          ev_pincfg = (wd16 <= PIN_CODE_MAX);
          ev_perr   = (wd16 > PIN_CODE_MAX);
        end
        CS_BUF_CNT: begin
          nxt_cst = (wd16 > BUF_N_MAX) ? CS_IDLE : CS_BUF_DATA;
          ev_perr = (wd16 > BUF_N_MAX);
          ev_eerr = (wd16 > BUF_N_MAX);
        end
        CS_BUF_DATA: begin
          // Every word must stay inside the same 16-word line
          if (faddr_ff[21:4] != bbase_ff) begin
            nxt_cst = CS_IDLE;
            ev_perr = 1'b1;
            ev_eerr = 1'b1;
          end else begin
            ev_load = 1'b1;
            nxt_cst = (bcnt_ff == 4'h0) ? CS_BUF_CONF : CS_BUF_DATA;
          end
        end
        CS_BUF_CONF: begin
          nxt_cst = CS_IDLE;
          if (c != CMD_CONFIRM) begin
            ev_perr = 1'b1;
            ev_eerr = 1'b1;
          end else if (block_protected) begin
            ev_bperr = 1'b1;
            ev_perr  = 1'b1;
          end else begin
            ev_start = 1'b1;
            nxt_op   = OP_BUF;
          end
        end
        default: nxt_cst = CS_IDLE;
      endcase
    end
  end

  // Avalon slave: registers and answers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h00000000;
      faddr_ff <= 22'h000000;
    end else begin
      wait_ff <= ~req_new;
      if (req_new && avs_read) begin
        case (avs_address)
          OFF_ADDR:   rdata_ff <= {10'h000, faddr_ff};
          OFF_DATA:   rdata_ff <= {16'h0000, read_word};
          OFF_STATUS: rdata_ff <= {24'h000000, status_byte};
          OFF_BCR:    rdata_ff <= {16'h0000, bcr_ff};
          OFF_PINCFG: rdata_ff <= {30'h00000000, pin_cfg_ff};
          default:    rdata_ff <= 32'h00000000;
        endcase
      end
      if (req_new && avs_write && avs_address == OFF_ADDR) begin
        faddr_ff <= fpc_be_merge(faddr_ff, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cst_ff   <= CS_IDLE;
      rmode_ff <= RM_ARRAY;
    end else begin
      cst_ff   <= nxt_cst;
      rmode_ff <= nxt_rmode;
    end
  end

  // Buffered program bookkeeping
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bcnt_ff  <= 4'h0;
      bbase_ff <= 18'h00000;
    end else if (wr_cmd && cst_ff == CS_IDLE && c == CMD_BUF_PROG) begin
      bbase_ff <= faddr_ff[21:4];
    end else if (wr_cmd && cst_ff == CS_BUF_CNT) begin
      bcnt_ff <= wd16[3:0];
    end else if (ev_load) begin
      bcnt_ff <= bcnt_ff - 4'h1;
    end
  end

  // Controller activity and suspension
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_ff     <= 1'b0;
      act_op_ff     <= OP_WORD;
      susp_req_ff   <= 1'b0;
      susp_erase_ff <= 1'b0;
      susp_prog_ff  <= 1'b0;
    end else begin
      act_op_ff <= nxt_op;
      if (pe_done || pe_fail || pe_paused) begin
        active_ff   <= 1'b0;
        susp_req_ff <= 1'b0;
      end
      if (ev_suspend) begin
        susp_req_ff <= 1'b1;
      end
      if (pe_paused) begin
        susp_erase_ff <= susp_erase_ff | (act_op_ff == OP_ERASE);
        susp_prog_ff  <= susp_prog_ff | (act_op_ff != OP_ERASE);
      end
      if (ev_start) begin
        active_ff <= 1'b1;
      end
      // A program nested in erase suspend resumes first
      if (ev_resume) begin
        active_ff <= 1'b1;
        if (susp_prog_ff) begin
          susp_prog_ff <= 1'b0;
        end else begin
          susp_erase_ff <= 1'b0;
          act_op_ff     <= OP_ERASE;
        end
      end
    end
  end

  // Sticky errors; a set in the clear cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_erase_ff <= 1'b0;
      err_prog_ff  <= 1'b0;
      err_bp_ff    <= 1'b0;
    end else begin
      if (ev_clear) begin
        err_erase_ff <= 1'b0;
        err_prog_ff  <= 1'b0;
        err_bp_ff    <= 1'b0;
      end
      if (ev_eerr || (pe_fail && (act_op_ff == OP_ERASE || act_op_ff == OP_UNPROT))) begin
        err_erase_ff <= 1'b1;
      end
      if (ev_perr || (pe_fail && act_op_ff != OP_ERASE && act_op_ff != OP_UNPROT)) begin
        err_prog_ff <= 1'b1;
      end
      if (ev_bperr) begin
        err_bp_ff <= 1'b1;
      end
    end
  end

  // Burst configuration and status pin setting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bcr_ff     <= BCR_RESET;
      pin_cfg_ff <= PIN_READY_BUSY;
    end else begin
      if (ev_bcr) begin
        bcr_ff <= faddr_ff[15:0];
      end
      if (ev_pincfg) begin
        pin_cfg_ff <= wd16[1:0];
      end
    end
  end

  // Status pin is open drain: only ever pulled low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcnt_ff     <= 4'h0;
      pin_oe_n_ff <= 1'b1;
      pin_o_ff    <= 1'b0;
    end else if (pin_cfg_ff == PIN_READY_BUSY) begin
      pcnt_ff     <= 4'h0;
      pin_oe_n_ff <= ~active_ff;
    end else if (pe_done &&
                 (((pin_cfg_ff == PIN_PULSE_ERASE || pin_cfg_ff == PIN_PULSE_ANY) &&
                   act_op_ff == OP_ERASE) ||
                  ((pin_cfg_ff == PIN_PULSE_PROG || pin_cfg_ff == PIN_PULSE_ANY) &&
                   (act_op_ff == OP_WORD || act_op_ff == OP_BUF)))) begin
      pcnt_ff     <= PULSE_CYC;
      pin_oe_n_ff <= 1'b0;
    end else if (pcnt_ff > 4'h1) begin
      pcnt_ff <= pcnt_ff - 4'h1;
    end else begin
      pcnt_ff     <= 4'h0;
      pin_oe_n_ff <= 1'b1;
    end
  end

  // Requests to the controller; protection flags stay in its storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pe_start_ff <= 1'b0;
      pe_op_ff    <= OP_WORD;
      pe_addr_ff  <= 22'h000000;
      pe_data_ff  <= 16'h0000;
      pe_load_ff  <= 1'b0;
      pe_susp_ff  <= 1'b0;
      pe_res_ff   <= 1'b0;
    end else begin
      pe_start_ff <= ev_start;
      pe_load_ff  <= ev_load;
      pe_susp_ff  <= ev_suspend;
      pe_res_ff   <= ev_resume;
      if (ev_start) begin
        pe_op_ff <= nxt_op;
      end
      if (ev_start || ev_load) begin
        pe_addr_ff <= faddr_ff;
        pe_data_ff <= wd16;
      end
    end
  end

  assign avs_readdata              = rdata_ff;
  assign avs_waitrequest           = wait_ff;
  assign store_addr                = faddr_ff;
  assign pe_start                  = pe_start_ff;
  assign pe_op                     = pe_op_ff;
  assign pe_addr                   = pe_addr_ff;
  assign pe_data                   = pe_data_ff;
  assign pe_buf_load               = pe_load_ff;
  assign pe_suspend                = pe_susp_ff;
  assign pe_resume                 = pe_res_ff;
  assign status_indicator_pin_o    = pin_o_ff;
  assign status_indicator_pin_oe_n = pin_oe_n_ff;
  assign burst_config_value        = bcr_ff;
endmodule // fpc_cmd_decoder
`default_nettype wire

// *** logic/fpc_pkg.sv ***
// Constants and types of the flash command decoder.
// Assumes one 20 MHz clock shared with the Avalon-MM master and the P/E controller.
package fpc_pkg;
  // Avalon-MM register map, byte addresses
  localparam int         AVS_AW     = 5;
  localparam logic [4:0] OFF_ADDR   = 5'h00;
  localparam logic [4:0] OFF_CMD    = 5'h04;
  localparam logic [4:0] OFF_DATA   = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_BCR    = 5'h10;
  localparam logic [4:0] OFF_PINCFG = 5'h14;
  localparam int         FA_W       = 22;

  // First and second cycle command codes
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_PROG_A      = 8'h40;
  localparam logic [7:0] CMD_PROG_B      = 8'h10;
  localparam logic [7:0] CMD_BUF_PROG    = 8'hE8;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_CFG_SETUP   = 8'h60;
  localparam logic [7:0] CMD_CFG_BURST   = 8'h03;
  localparam logic [7:0] CMD_CFG_PROTECT = 8'h01;
  localparam logic [7:0] CMD_OTP_PROG    = 8'hC0;
  localparam logic [7:0] CMD_PIN_CFG     = 8'hB8;

  // Status pin modes, pin code limit and buffer word count limit
  localparam logic [1:0]  PIN_READY_BUSY  = 2'h0;
  localparam logic [1:0]  PIN_PULSE_ERASE = 2'h1;
  localparam logic [1:0]  PIN_PULSE_PROG  = 2'h2;
  localparam logic [1:0]  PIN_PULSE_ANY   = 2'h3;
  localparam logic [15:0] PIN_CODE_MAX    = 16'h0003;
  localparam logic [15:0] BUF_N_MAX       = 16'h000F;

  // Status register bit positions
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_EERR  = 5;
  localparam int SR_PERR  = 4;
  localparam int SR_PSUSP = 2;
  localparam int SR_BPERR = 1;

  localparam logic [15:0] BCR_RESET = 16'h0000;

  // Identifier and protection register word addresses
  localparam logic [21:0] ID_MFR_ADDR  = 22'h000000;
  localparam logic [21:0] ID_DEV_ADDR  = 22'h000001;
  localparam logic [15:0] ID_PROT_OFS  = 16'h0002;
  localparam logic [21:0] ID_BCR_ADDR  = 22'h000005;
  localparam logic [21:0] OTP_LOCK     = 22'h000080;
  localparam logic [21:0] OTP_FACT_HI  = 22'h000084;
  localparam logic [21:0] OTP_USER_LO  = 22'h000085;
  localparam logic [21:0] OTP_USER_HI  = 22'h000088;

  // Status pin pulse: typical 250 ns, rounded down to whole cycles
  localparam int         CLK_HZ    = 20000000;
  localparam int         PULSE_NS  = 250;
  localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS * (CLK_HZ / 1000000)) / 1000);

  typedef enum logic [1:0] {
    RM_ARRAY  = 2'h0,
    RM_STATUS = 2'h1,
    RM_IDENT  = 2'h2,
    RM_QUERY  = 2'h3
  } fpc_rmode_t;

  typedef enum logic [3:0] {
    CS_IDLE     = 4'h0,
    CS_CFG60    = 4'h1,
    CS_ERASE    = 4'h2,
    CS_WORD     = 4'h3,
    CS_OTP      = 4'h4,
    CS_PINCFG   = 4'h5,
    CS_BUF_CNT  = 4'h6,
    CS_BUF_DATA = 4'h7,
    CS_BUF_CONF = 4'h8
  } fpc_cst_t;

  typedef enum logic [2:0] {
    OP_WORD   = 3'h0,
    OP_BUF    = 3'h1,
    OP_ERASE  = 3'h2,
    OP_PROT   = 3'h3,
    OP_UNPROT = 3'h4,
    OP_OTP    = 3'h5
  } fpc_op_t;
endpackage

// *** sim/fpc_chk_sva.sv ***
// Port checker of the flash command decoder.
// Assumes one clock and the async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fpc_chk import fpc_pkg::*; (
  input wire logic        clk, rstn, avs_read, avs_write, avs_waitrequest,
  input wire logic        pe_start, pe_suspend, pe_resume, status_indicator_pin_o,
  input wire logic [4:0]  avs_address,
  input wire logic [2:0]  pe_op,
  input wire logic [21:0] store_addr,
  input wire logic [15:0] burst_config_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_od;
    status_indicator_pin_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_src;
    pe_start |-> $past(avs_write && avs_waitrequest && avs_address == OFF_CMD);
  endproperty
  a_src: assert property (p_src) else $error("start without write");
  property p_pls;
    pe_start |=> !pe_start;
  endproperty
  a_pls: assert property (p_pls) else $error("long start");
  property p_prot;
    pe_start && pe_op inside {OP_PROT, OP_UNPROT}
      |=> (!pe_start && !pe_suspend && !pe_resume) [*8];
  endproperty
  a_prot: assert property (p_prot) else $error("command taken in protect");
  property p_otp;
    pe_op == OP_OTP |-> !pe_suspend;
  endproperty
  a_otp: assert property (p_otp) else $error("otp suspended");
  property p_bcr;
    $changed(burst_config_value)
      |-> $past(avs_write) && burst_config_value == $past(store_addr[15:0]);
  endproperty
  a_bcr: assert property (p_bcr) else $error("burst value wrong");
endmodule // fpc_chk
bind fpc_cmd_decoder fpc_chk i_fpc_chk (.*);
`default_nettype wire

// *** sim/fpc_flash_model.sv ***
// Storage and program/erase controller stand-in.
// Each operation ends a fixed time after its start pulse.
`timescale 1ns/10ps
`default_nettype none
module fpc_flash_model import fpc_pkg::*; #(
  parameter int BUSY = 20
) (
  input wire logic        clk, rstn, pe_start,
  input wire logic [2:0]  pe_op,
  input wire logic [21:0] store_addr, pe_addr,
  output logic     [15:0] array_word, query_word, otp_word,
  output logic     [1:0]  otp_lock,
  output logic            block_protected, pe_done, pe_fail, pe_paused
);
  logic [63:0] prot_ff = '0;
  int          cnt_ff;
  assign array_word = ~store_addr[15:0];
  assign query_word = store_addr[15:0] ^ 16'h5A5A;
  assign otp_word = store_addr[15:0];
  assign otp_lock = 2'b10; // Factory half locked
  assign block_protected = prot_ff[store_addr[21:16]];
  assign pe_fail = 1'b0;
  assign pe_paused = 1'b0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 0;
      pe_done <= 1'b0;
    end else begin
      pe_done <= cnt_ff == 1;
      cnt_ff <= pe_start ? BUSY : cnt_ff - (cnt_ff > 0);
    end
  end
  // No reset: flags survive it
  always_ff @(posedge clk) begin
    if (pe_start && pe_op == OP_PROT) prot_ff[pe_addr[21:16]] <= 1'b1;
    if (pe_start && pe_op == OP_UNPROT) prot_ff <= '0;
  end
endmodule // fpc_flash_model
`default_nettype wire

// *** sim/fpc_cmd_decoder_test.sv ***
// Self-checking bench of the flash command decoder.
// Decoder, storage model and checker share one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module fpc_cmd_decoder_test;
  import fpc_pkg::*;
  logic        clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
  logic [4:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q, seed = 32'h346A;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, block_protected, pe_start, pe_buf_load, pe_suspend;
  logic        pe_resume, pe_done, pe_fail, pe_paused;
  logic        status_indicator_pin_o, status_indicator_pin_oe_n;
  logic [15:0] array_word, query_word, otp_word, pe_data, burst_config_value;
  logic [21:0] store_addr, pe_addr, a;
  logic [2:0]  pe_op;
  logic [1:0]  otp_lock;
  int          num_errors = 0, total_checks = 0, n, k;
  fpc_cmd_decoder i_fpc_cmd_decoder (.*);
  fpc_flash_model i_fpc_flash_model (.*);
  initial forever #25 clk = ~clk;
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= ad;
    avs_writedata <= d;
    n = 0;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && n++ < 50);
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      conclude();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmd(input logic [21:0] ad, input logic [15:0] c);
    bus(1, OFF_ADDR, {10'h0, ad});
    bus(1, OFF_CMD, {16'h0, c});
  endtask
  task automatic rdchk(input logic [4:0] ad, input logic [31:0] exp);
    bus(0, ad, 0);
    chk(q, exp);
  endtask
  task automatic idle;
    for (int i = 0; i < 40; i++) begin
      bus(0, OFF_STATUS, 0);
      if (q[7]) return;
    end
    num_errors++;
    conclude();
  endtask
  function automatic logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rdchk(OFF_BCR, 0);
    rdchk(OFF_PINCFG, 0);
    rdchk(OFF_STATUS, 32'h80);
    repeat (3) begin
      a = 22'(xs());
      cmd(a, 8'h60);
      cmd(a, 8'h03);
      rdchk(OFF_BCR, {16'h0, a[15:0]});
      rdchk(OFF_DATA, {16'h0, ~a[15:0]});
    end
    cmd(0, 8'h90);
    rdchk(OFF_DATA, 32'h00A5);
    cmd(a, 8'h98);
    rdchk(OFF_DATA, {16'h0, a[15:0] ^ 16'h5A5A});
    a = 22'h0A0000;
    cmd(a, 8'h60);
    cmd(a, 8'h01);
    cmd(a, 8'hFF);
    rdchk(OFF_DATA, 0);
    chk(status_indicator_pin_oe_n, 0);
    idle();
    rdchk(OFF_DATA, 32'h80);
    cmd(a + 2, 8'h90);
    rdchk(OFF_DATA, 1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    cmd(a + 2, 8'h90);
    rdchk(OFF_DATA, 1);
    cmd(a, 8'h60);
    cmd(a, 8'hD0);
    idle();
    cmd(a + 2, 8'h90);
    rdchk(OFF_DATA, 0);
    cmd(OTP_USER_LO, 8'hC0);
    cmd(OTP_USER_LO, 16'h1234);
    cmd(0, 8'hB0);
    rdchk(OFF_DATA, 0);
    idle();
    cmd(OTP_FACT_HI, 8'hC0);
    cmd(OTP_FACT_HI, 16'h1234);
    rdchk(OFF_STATUS, 32'h90);
    cmd(0, 8'h50);
    rdchk(OFF_STATUS, 32'h80);
    for (int c = 0; c < 5; c++) begin
      cmd(0, 8'hB8);
      cmd(0, 16'(c));
      rdchk(OFF_PINCFG, c < 4 ? c : 3);
    end
    rdchk(OFF_STATUS, 32'h90);
    cmd(0, 8'h50);
    cmd(0, 8'hB8);
    cmd(0, 8'h02);
    cmd(a, 8'h40);
    cmd(a, 16'hBEEF);
    chk(pe_data, 16'hBEEF);
    chk(pe_addr, a);
    k = 0;
    repeat (40) @(negedge clk) k += (status_indicator_pin_oe_n === 1'b0);
    chk(32'(k), 32'(PULSE_CYC));
    cmd(a, 8'hE8);
    cmd(a, 16'h0001);
    cmd(a, 16'h1111);
    chk(pe_buf_load, 1);
    cmd(a + 1, 16'h2222);
    cmd(a, 8'hD0);
    chk(pe_op, OP_BUF);
    idle();
    cmd(a, 8'h20);
    cmd(a, 8'hD0);
    cmd(0, 8'hB8);
    cmd(0, 8'h03);
    rdchk(OFF_PINCFG, 2);
    idle();
    conclude();
  end
endmodule // fpc_cmd_decoder_test
`default_nettype wire
